// file: rtl/spcfg_bank.sv
// Purpose: Port configuration register bank with serial-memory load and host access
// Assumes: Memory read port answers one byte per request with a valid strobe
// Notes:   Host access arrives already decoded from vendor control requests
`timescale 1ns/100ps
`include "spcfg_defines.svh"
module spcfg_bank #(
   parameter logic [15:0] PRESENCE_WORD = 16'h5a5a  // Arbitrary value
) (
   input  wire logic                 clk_sys,
   input  wire logic                 nrst,
   output logic                      ee_req,
   output logic [7:0]                ee_addr,
   input  wire logic                 ee_valid,
   input  wire logic [7:0]           ee_data,
   input  wire logic                 ee_absent,
   input  wire logic                 host_valid,
   input  wire logic [7:0]           host_request,
   input  wire logic [7:0]           host_app,
   input  wire logic [7:0]           host_index,
   input  wire logic [7:0]           host_wdata,
   output logic [7:0]                host_rdata,
   output logic                      host_ack,
   output logic                      host_nak,
   output logic                      load_done,
   output logic                      ee_present,
   input  wire logic [1:0]           modem_rts,
   input  wire logic [1:0]           tx_buf_empty,
   input  wire spcfg_pkg::spcfg_lines_t lines1,
   input  wire spcfg_pkg::spcfg_lines_t lines2,
   input  wire logic                 usb_suspended,
   output logic [1:0]                rts_pin_n,
   output logic [1:0]                ir_mode,
   output logic [1:0]                wake_allowed,
   output logic                      remote_wake_req,
   output spcfg_pkg::spcfg_port_t    port1_cfg,
   output spcfg_pkg::spcfg_port_t    port2_cfg
);
   spcfg_pkg::spcfg_state_t state;
   spcfg_pkg::spcfg_state_t next_state;
   spcfg_pkg::spcfg_port_t  next_port1_cfg;
   spcfg_pkg::spcfg_port_t  next_port2_cfg;
   logic [1:0]              pos;
   logic [1:0]              next_pos;
   logic [7:0]              sig_lo;
   logic [7:0]              next_sig_lo;
   logic                    req_out;
   logic                    next_req_out;
   logic                    next_ee_present;
   logic [7:0]              next_host_rdata;
   logic                    next_host_ack;
   logic                    next_host_nak;
   logic [1:0]              wake;

   // Writable-bit mask per index; zero means unmapped
   function automatic logic [7:0] wmask(input logic [7:0] idx);
      unique case (idx)
         `SPCFG_IDX_P1_CFG0: wmask = `SPCFG_WMASK_P1_CFG0;
         `SPCFG_IDX_P1_CFG1: wmask = `SPCFG_WMASK_P1_CFG1;
         `SPCFG_IDX_P1_CFG2: wmask = `SPCFG_WMASK_P1_CFG2;
         `SPCFG_IDX_P2_CFG0: wmask = `SPCFG_WMASK_P2_CFG0;
         `SPCFG_IDX_P2_CFG1: wmask = `SPCFG_WMASK_P2_CFG1;
         `SPCFG_IDX_P2_CFG2: wmask = `SPCFG_WMASK_P2_CFG2;
         default:            wmask = 8'h00;
      endcase
   endfunction : wmask

   function automatic logic mapped(input logic [7:0] idx);
      mapped = (idx == `SPCFG_IDX_P1_CFG0) || (idx == `SPCFG_IDX_P1_CFG1)
            || (idx == `SPCFG_IDX_P1_CFG2) || (idx == `SPCFG_IDX_P2_CFG0)
            || (idx == `SPCFG_IDX_P2_CFG1) || (idx == `SPCFG_IDX_P2_CFG2);
   endfunction : mapped

   assign load_done       = (state == spcfg_pkg::SPCFG_DONE);
   assign ee_req          = req_out;
   assign remote_wake_req = |wake;

   always_comb begin
      next_state      = state;
      next_port1_cfg  = port1_cfg;
      next_port2_cfg  = port2_cfg;
      next_pos        = pos;
      next_sig_lo     = sig_lo;
      next_req_out    = 1'b0;
      next_ee_present = ee_present;
      next_host_rdata = host_rdata;
      next_host_ack   = 1'b0;
      next_host_nak   = 1'b0;
      ee_addr         = `SPCFG_EE_ADDR_SIG_LO;
      unique case (state)
         spcfg_pkg::SPCFG_IDLE: begin
            if (ee_absent) begin
               next_state = spcfg_pkg::SPCFG_DONE;
            end else begin
               next_req_out = 1'b1;
               next_state   = spcfg_pkg::SPCFG_SIG0;
            end
         end
         spcfg_pkg::SPCFG_SIG0: begin
            ee_addr = `SPCFG_EE_ADDR_SIG_LO;
            if (ee_valid) begin
               next_sig_lo  = ee_data;
               next_req_out = 1'b1;
               next_state   = spcfg_pkg::SPCFG_SIG1;
            end
         end
         spcfg_pkg::SPCFG_SIG1: begin
            ee_addr = `SPCFG_EE_ADDR_SIG_HI;
            if (ee_valid) begin
               if ({ee_data, sig_lo} == PRESENCE_WORD) begin
                  next_ee_present = 1'b1;
                  next_req_out    = 1'b1;
                  next_pos        = 2'd0;
                  next_state      = spcfg_pkg::SPCFG_LOAD1;
               end else begin
                  next_state = spcfg_pkg::SPCFG_DONE;
               end
            end
         end
         spcfg_pkg::SPCFG_LOAD1: begin
            ee_addr = `SPCFG_EE_ADDR_P1 + {6'h00, pos};
            if (ee_valid) begin
               next_port1_cfg[pos*8 +: 8] = ee_data & wmask(`SPCFG_IDX_P1_CFG0 + {6'h00, pos});
               next_req_out = 1'b1;
               next_pos     = (pos == 2'd2) ? 2'd0 : pos + 2'd1;
               if (pos == 2'd2) begin
                  next_state = spcfg_pkg::SPCFG_LOAD2;
               end
            end
         end
         spcfg_pkg::SPCFG_LOAD2: begin
            ee_addr = `SPCFG_EE_ADDR_P2 + {6'h00, pos};
            if (ee_valid) begin
               next_port2_cfg[pos*8 +: 8] = ee_data & wmask(`SPCFG_IDX_P2_CFG0 + {6'h00, pos});
               next_pos = pos + 2'd1;
               if (pos == 2'd2) begin
                  next_state = spcfg_pkg::SPCFG_DONE;
               end else begin
                  next_req_out = 1'b1;
               end
            end
         end
         spcfg_pkg::SPCFG_DONE: begin
            if (host_valid) begin
               if (host_app != `SPCFG_APP_NUM || !mapped(host_index)) begin
                  next_host_nak = 1'b1;
               end else if (host_request == `SPCFG_REQ_WRITE) begin
                  next_host_ack = 1'b1;
                  unique case (host_index)
                     `SPCFG_IDX_P1_CFG0: next_port1_cfg.cfg0 = host_wdata & wmask(host_index);
                     `SPCFG_IDX_P1_CFG1: next_port1_cfg.cfg1 = host_wdata & wmask(host_index);
                     `SPCFG_IDX_P1_CFG2: next_port1_cfg.cfg2 = host_wdata & wmask(host_index);
                     `SPCFG_IDX_P2_CFG0: next_port2_cfg.cfg0 = host_wdata & wmask(host_index);
                     `SPCFG_IDX_P2_CFG1: next_port2_cfg.cfg1 = host_wdata & wmask(host_index);
                     default:            next_port2_cfg.cfg2 = host_wdata & wmask(host_index);
                  endcase
               end else if (host_request == `SPCFG_REQ_READ) begin
                  next_host_ack = 1'b1;
                  unique case (host_index)
                     `SPCFG_IDX_P1_CFG0: next_host_rdata = port1_cfg.cfg0;
                     `SPCFG_IDX_P1_CFG1: next_host_rdata = port1_cfg.cfg1;
                     `SPCFG_IDX_P1_CFG2: next_host_rdata = port1_cfg.cfg2;
                     `SPCFG_IDX_P2_CFG0: next_host_rdata = port2_cfg.cfg0;
                     `SPCFG_IDX_P2_CFG1: next_host_rdata = port2_cfg.cfg1;
                     default:            next_host_rdata = port2_cfg.cfg2;
                  endcase
               end else begin
                  next_host_nak = 1'b1;
               end
            end
         end
         default: next_state = spcfg_pkg::SPCFG_IDLE;
      endcase
      // Host requests before loading ends are refused
      if (host_valid && state != spcfg_pkg::SPCFG_DONE) begin
         next_host_nak = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state      <= spcfg_pkg::SPCFG_IDLE;
         port1_cfg  <= {`SPCFG_RST_P1_CFG2, `SPCFG_RST_P1_CFG1, `SPCFG_RST_P1_CFG0};
         port2_cfg  <= {`SPCFG_RST_P2_CFG2, `SPCFG_RST_P2_CFG1, `SPCFG_RST_P2_CFG0};
         pos        <= 2'd0;
         sig_lo     <= 8'h00;
         req_out    <= 1'b0;
         ee_present <= 1'b0;
         host_rdata <= 8'h00;
         host_ack   <= 1'b0;
         host_nak   <= 1'b0;
      end else begin
         state      <= next_state;
         port1_cfg  <= next_port1_cfg;
         port2_cfg  <= next_port2_cfg;
         pos        <= next_pos;
         sig_lo     <= next_sig_lo;
         req_out    <= next_req_out;
         ee_present <= next_ee_present;
         host_rdata <= next_host_rdata;
         host_ack   <= next_host_ack;
         host_nak   <= next_host_nak;
      end
   end

   spcfg_port_ctrl u_port1 (
      .clk_sys       (clk_sys),
      .nrst          (nrst),
      .cfg           (port1_cfg),
      .modem_rts     (modem_rts[0]),
      .tx_buf_empty  (tx_buf_empty[0]),
      .lines         (lines1),
      .usb_suspended (usb_suspended),
      .rts_pin_n     (rts_pin_n[0]),
      .ir_mode       (ir_mode[0]),
      .wake_allowed  (wake_allowed[0]),
      .wake_req      (wake[0])
   );

   spcfg_port_ctrl u_port2 (
      .clk_sys       (clk_sys),
      .nrst          (nrst),
      .cfg           (port2_cfg),
      .modem_rts     (modem_rts[1]),
      .tx_buf_empty  (tx_buf_empty[1]),
      .lines         (lines2),
      .usb_suspended (usb_suspended),
      .rts_pin_n     (rts_pin_n[1]),
      .ir_mode       (ir_mode[1]),
      .wake_allowed  (wake_allowed[1]),
      .wake_req      (wake[1])
   );
endmodule : spcfg_bank

// file: rtl/spcfg_defines.svh
// Purpose: Offsets, field positions, reset values and signature addresses for the port configuration bank
// Assumes: Included by its bare name
// Notes:   Register indexes are those of application number 0
`ifndef SPCFG_DEFINES_SVH
`define SPCFG_DEFINES_SVH

`define SPCFG_APP_NUM         8'h00
`define SPCFG_REQ_WRITE       8'h0e
`define SPCFG_REQ_READ        8'h0d

`define SPCFG_IDX_P1_CFG0     8'h04
`define SPCFG_IDX_P1_CFG1     8'h05
`define SPCFG_IDX_P1_CFG2     8'h06
`define SPCFG_IDX_P2_CFG0     8'h19
`define SPCFG_IDX_P2_CFG1     8'h1a
`define SPCFG_IDX_P2_CFG2     8'h1b

`define SPCFG_RST_P1_CFG0     8'h01
`define SPCFG_RST_P1_CFG1     8'h85
`define SPCFG_RST_P1_CFG2     8'h24
`define SPCFG_RST_P2_CFG0     8'h01
`define SPCFG_RST_P2_CFG1     8'h84
`define SPCFG_RST_P2_CFG2     8'h24

// Writable bits; port 2 reserved fields read as zero, except cfg1 bit 7, which reset value 8'h84 sets until written or loaded
`define SPCFG_WMASK_P1_CFG0   8'h7f
`define SPCFG_WMASK_P1_CFG1   8'hff
`define SPCFG_WMASK_P1_CFG2   8'hff
`define SPCFG_WMASK_P2_CFG0   8'h71
`define SPCFG_WMASK_P2_CFG1   8'h1c
`define SPCFG_WMASK_P2_CFG2   8'h3f

`define SPCFG_EE_ADDR_SIG_LO  8'h00
`define SPCFG_EE_ADDR_SIG_HI  8'h01
`define SPCFG_EE_ADDR_P1      8'h08
`define SPCFG_EE_ADDR_P2      8'h0e

`define SPCFG_BIT_IR_MODE     6
`define SPCFG_BIT_RTS_LO      4
`define SPCFG_BIT_WAKE_INHIB  4

`define SPCFG_RTS_CTRL_LOW    2'b00
`define SPCFG_RTS_CTRL_HIGH   2'b01
`define SPCFG_RTS_DATA        2'b10

`endif

// file: rtl/spcfg_pkg.sv
// Purpose: Types shared by the port configuration bank
// Assumes: Constants live in spcfg_defines.svh
// Notes:   One struct per port configuration triple
package spcfg_pkg;
   typedef struct packed {
      logic [7:0] cfg2;
      logic [7:0] cfg1;
      logic [7:0] cfg0;
   } spcfg_port_t;

   typedef struct packed {
      logic       cts;
      logic       dcd;
      logic       ring;
      logic       dsr;
      logic       rxd;
   } spcfg_lines_t;

   typedef enum logic [5:0] {
      SPCFG_IDLE  = 6'b000001,
      SPCFG_SIG0  = 6'b000010,
      SPCFG_SIG1  = 6'b000100,
      SPCFG_LOAD1 = 6'b001000,
      SPCFG_LOAD2 = 6'b010000,
      SPCFG_DONE  = 6'b100000
   } spcfg_state_t;
endpackage : spcfg_pkg

// file: rtl/spcfg_port_ctrl.sv
// Purpose: Per-port RTS drive and wake-up trigger logic from one configuration triple
// Assumes: Modem lines are synchronous to clk_sys
// Notes:   Wake request is a one-cycle pulse
`timescale 1ns/100ps
`include "spcfg_defines.svh"
module spcfg_port_ctrl (
   input  wire logic                 clk_sys,
   input  wire logic                 nrst,
   input  wire spcfg_pkg::spcfg_port_t cfg,
   input  wire logic                 modem_rts,
   input  wire logic                 tx_buf_empty,
   input  wire spcfg_pkg::spcfg_lines_t lines,
   input  wire logic                 usb_suspended,
   output logic                      rts_pin_n,
   output logic                      ir_mode,
   output logic                      wake_allowed,
   output logic                      wake_req
);
   spcfg_pkg::spcfg_lines_t prev_lines;
   spcfg_pkg::spcfg_lines_t next_prev_lines;
   logic                    next_rts_pin_n;
   logic                    next_wake_req;
   logic                    primed;
   logic                    next_primed;
   logic [4:0]              changed;
   logic [1:0]              rts_sel;

   assign rts_sel      = cfg.cfg0[`SPCFG_BIT_RTS_LO+1:`SPCFG_BIT_RTS_LO];
   assign ir_mode      = cfg.cfg0[`SPCFG_BIT_IR_MODE];
   assign wake_allowed = !cfg.cfg0[`SPCFG_BIT_IR_MODE]
                         && !cfg.cfg1[`SPCFG_BIT_WAKE_INHIB];
   // No history on the first cycle after reset, so no edge whatever the line levels
   assign changed      = (lines ^ prev_lines) & {5{primed}};

   always_comb begin
      next_prev_lines = lines;
      next_primed     = 1'b1;
      unique case (rts_sel)
         `SPCFG_RTS_CTRL_LOW:  next_rts_pin_n = !modem_rts;
         `SPCFG_RTS_CTRL_HIGH: next_rts_pin_n = modem_rts;
         `SPCFG_RTS_DATA:      next_rts_pin_n = tx_buf_empty;
         default:              next_rts_pin_n = 1'b1;
      endcase
      // Bit order cts,dcd,ring,dsr,rxd maps to enables 0..4
      next_wake_req = usb_suspended && wake_allowed
                      && |(changed & {cfg.cfg2[0], cfg.cfg2[1], cfg.cfg2[2],
                                      cfg.cfg2[3], cfg.cfg2[4]});
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prev_lines <= '0;
         primed     <= 1'b0;
         rts_pin_n  <= 1'b1;
         wake_req   <= 1'b0;
      end else begin
         prev_lines <= next_prev_lines;
         primed     <= next_primed;
         rts_pin_n  <= next_rts_pin_n;
         wake_req   <= next_wake_req;
      end
   end
endmodule : spcfg_port_ctrl

// file: verification/spcfg_bank_assertions.sv
// Purpose: Port-level checks of the configuration bank
// Assumes: Single clock domain, reset active low
// Notes:   Attached by bind from the bench top
`timescale 1ns/100ps
module spcfg_bank_assertions (
   input wire logic                   clk_sys,
   input wire logic                   nrst,
   input wire logic                   ee_req,
   input wire logic                   host_valid,
   input wire logic [7:0]             host_app,
   input wire logic                   host_ack,
   input wire logic                   host_nak,
   input wire logic                   load_done,
   input wire logic [1:0]             modem_rts,
   input wire logic [1:0]             tx_buf_empty,
   input wire spcfg_pkg::spcfg_lines_t lines1,
   input wire logic                   usb_suspended,
   input wire logic [1:0]             rts_pin_n,
   input wire logic [1:0]             ir_mode,
   input wire logic [1:0]             wake_allowed,
   input wire logic                   remote_wake_req,
   input wire spcfg_pkg::spcfg_port_t port1_cfg,
   input wire spcfg_pkg::spcfg_port_t port2_cfg
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence cts_trigger;
      $past(nrst) && usb_suspended && wake_allowed[0] && port1_cfg.cfg2[0]
         && $changed(lines1.cts);
   endsequence
   sequence wake_pulse;
      ##[1:2] remote_wake_req;
   endsequence
   AST_ANSWER: assert property (host_valid |=> host_ack != host_nak)
      else $error("host request not answered by exactly one of ack and nak");
   AST_NAK_EARLY: assert property (host_valid && !load_done |=> host_nak)
      else $error("host request before load finished was not refused");
   AST_NAK_APP: assert property (host_valid && host_app != 8'h00 |=> host_nak)
      else $error("host request to another application was not refused");
   AST_IR: assert property (ir_mode == {port2_cfg.cfg0[6], port1_cfg.cfg0[6]})
      else $error("infrared mode does not follow register 0 bit 6");
   AST_WAKE_GATE: assert property (
      wake_allowed[0] == (!port1_cfg.cfg0[6] && !port1_cfg.cfg1[4]))
      else $error("wake gate does not follow infrared and inhibit bits");
   AST_P2_RSV: assert property (
      load_done |-> ((port2_cfg.cfg0 & 8'h8e) | (port2_cfg.cfg1 & 8'h03)
                     | (port2_cfg.cfg2 & 8'hc0)) == 8'h00)
      else $error("port 2 reserved bits not zero");
   AST_RTS_LOW: assert property (
      port1_cfg.cfg0[5:4] == 2'b00 |=> rts_pin_n[0] == !$past(modem_rts[0]))
      else $error("rts mode 00 wrong pin level");
   AST_RTS_HIGH: assert property (
      port2_cfg.cfg0[5:4] == 2'b01 |=> rts_pin_n[1] == $past(modem_rts[1]))
      else $error("rts mode 01 wrong pin level");
   AST_RTS_DATA: assert property (
      port1_cfg.cfg0[5:4] == 2'b10 |=> rts_pin_n[0] == $past(tx_buf_empty[0]))
      else $error("rts data mode wrong pin level");
   AST_WAKE_CTS: assert property (cts_trigger |-> wake_pulse)
      else $error("enabled trigger change while suspended gave no wake request");
   AST_WAKE_SLEEP: assert property (
      remote_wake_req |-> $past(usb_suspended) || $past(usb_suspended, 2))
      else $error("wake request while link not suspended");
   AST_EE_PULSE: assert property (ee_req |=> !ee_req)
      else $error("memory request longer than one cycle");
endmodule : spcfg_bank_assertions

// file: verification/spcfg_ee_model.sv
// Purpose: Serial configuration memory answering byte requests
// Assumes: One request outstanding at a time
// Notes:   Data line changes every cycle outside a valid answer
`timescale 1ns/100ps
module spcfg_ee_model (
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       ee_req,
   input  wire logic [7:0] ee_addr,
   input  wire logic       bad_sig,
   input  wire logic       slow,
   output logic            ee_valid,
   output logic [7:0]      ee_data
);
   logic [7:0] addr_q;
   int         wait_n;
   function automatic logic [7:0] rom(input logic [7:0] a);
      case (a)
         8'h00:   rom = bad_sig ? 8'h00 : 8'h5a;
         8'h01:   rom = 8'h5a;
         8'h08:   rom = 8'h92;
         8'h09:   rom = 8'h10;
         8'h0a:   rom = 8'h1f;
         default: rom = 8'hff;
      endcase
   endfunction : rom
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ee_valid <= 1'b0;
         ee_data  <= 8'h00;
         wait_n   <= -1;
      end else begin
         ee_valid <= 1'b0;
         ee_data  <= ~ee_data;
         if (ee_req) begin
            addr_q <= ee_addr;
            wait_n <= slow ? 3 : 0;
         end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
         end else if (wait_n == 0) begin
            ee_valid <= 1'b1;
            ee_data  <= rom(addr_q);
            wait_n   <= -1;
         end
      end
   end
endmodule : spcfg_ee_model

// file: verification/test_spcfg_bank.sv
// Purpose: Self-checking bench for the configuration bank
// Assumes: Inputs driven at the falling edge
// Notes:   Memory model holds the presence word of the default parameter
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_spcfg_bank;
   logic                    clk_sys = 1'b0, nrst = 1'b0, ee_absent = 1'b0;
   logic                    bad_sig = 1'b0, slow = 1'b0, host_valid = 1'b0;
   logic                    ee_req, ee_valid, host_ack, host_nak, load_done, ee_present;
   logic                    remote_wake_req, usb_suspended = 1'b1;
   logic [7:0]              ee_addr, ee_data, host_rdata, host_wdata = 8'h00;
   logic [7:0]              host_request = 8'h0d, host_app = 8'h00, host_index = 8'h04;
   logic [1:0]              modem_rts = 2'b00, tx_buf_empty = 2'b11;
   logic [1:0]              rts_pin_n, ir_mode, wake_allowed;
   // Ring line high and link suspended through the first reset
   spcfg_pkg::spcfg_lines_t lines1 = 5'h04, lines2 = '0;
   spcfg_pkg::spcfg_port_t  port1_cfg, port2_cfg;
   int                      n_fail = 0, compares = 0;
   always #20 clk_sys = ~clk_sys;
   spcfg_bank spcfg_bank_inst (.clk_sys, .nrst, .ee_req, .ee_addr, .ee_valid, .ee_data,
      .ee_absent, .host_valid, .host_request, .host_app, .host_index, .host_wdata,
      .host_rdata, .host_ack, .host_nak, .load_done, .ee_present, .modem_rts,
      .tx_buf_empty, .lines1, .lines2, .usb_suspended, .rts_pin_n, .ir_mode,
      .wake_allowed, .remote_wake_req, .port1_cfg, .port2_cfg);
   spcfg_ee_model spcfg_ee_model_inst (.clk_sys, .nrst, .ee_req, .ee_addr, .bad_sig,
      .slow, .ee_valid, .ee_data);
   task automatic tally_and_finish;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic do_reset(input logic absent, input logic bad);
      @(negedge clk_sys);
      nrst = 1'b0;
      ee_absent = absent;
      bad_sig = bad;
      repeat (8) @(negedge clk_sys);
      nrst = 1'b1;
   endtask : do_reset
   task automatic wait_loaded;
      for (int k = 0; k < 300 && load_done !== 1'b1; k++)
         @(negedge clk_sys);
      `CHK(load_done, 1'b1)
   endtask : wait_loaded
   task automatic host_op(input logic [7:0] rq, ap, ix, wd, input logic ok,
                          output logic [7:0] rd);
      @(negedge clk_sys);
      host_valid = 1'b1;
      host_request = rq;
      host_app = ap;
      host_index = ix;
      host_wdata = wd;
      @(negedge clk_sys);
      host_valid = 1'b0;
      `CHK({host_ack, host_nak}, {ok, !ok})
      rd = host_rdata;
   endtask : host_op
   task automatic wr(input logic [7:0] ix, wd);
      logic [7:0] rd;
      host_op(8'h0e, 8'h00, ix, wd, 1'b1, rd);
   endtask : wr
   task automatic rd_chk(input logic [7:0] ix, ex);
      logic [7:0] rd;
      host_op(8'h0d, 8'h00, ix, 8'h00, 1'b1, rd);
      `CHK(rd, ex)
   endtask : rd_chk
   task automatic t_absent;
      do_reset(1'b1, 1'b0);
      @(negedge clk_sys);
      `CHK(remote_wake_req, 1'b0)
      usb_suspended = 1'b0;
      wait_loaded();
      `CHK(ee_present, 1'b0)
      `CHK({port2_cfg, port1_cfg}, 48'h248401_248501)
      $display("t_absent done");
   endtask : t_absent
   task automatic t_badsig;
      logic [7:0] rd;
      do_reset(1'b0, 1'b1);
      host_op(8'h0d, 8'h00, 8'h04, 8'h00, 1'b0, rd);
      wait_loaded();
      `CHK(ee_present, 1'b0)
      `CHK({port2_cfg, port1_cfg}, 48'h248401_248501)
      $display("t_badsig done");
   endtask : t_badsig
   task automatic t_load;
      slow = 1'b1;
      do_reset(1'b0, 1'b0);
      wait_loaded();
      slow = 1'b0;
      `CHK(ee_present, 1'b1)
      `CHK(port1_cfg, 24'h1f1012)
      `CHK(port2_cfg, 24'h3f1c71)
      $display("t_load done");
   endtask : t_load
   task automatic t_host;
      logic [7:0] rd;
      logic [7:0] ix[6] = '{8'h04, 8'h05, 8'h06, 8'h19, 8'h1a, 8'h1b};
      logic [7:0] mk[6] = '{8'h7f, 8'hff, 8'hff, 8'h71, 8'h1c, 8'h3f};
      for (int i = 0; i < 6; i++) begin
         wr(ix[i], 8'hff);
         rd_chk(ix[i], mk[i]);
         wr(ix[i], 8'h00);
         rd_chk(ix[i], 8'h00);
      end
      host_op(8'h0e, 8'h00, 8'h07, 8'h55, 1'b0, rd);
      host_op(8'h0e, 8'h01, 8'h04, 8'h55, 1'b0, rd);
      host_op(8'h0c, 8'h00, 8'h04, 8'h55, 1'b0, rd);
      rd_chk(8'h04, 8'h00);
      $display("t_host done");
   endtask : t_host
   task automatic t_rts;
      for (int p = 0; p < 2; p++)
         for (int m = 0; m < 4; m++)
            for (int v = 0; v < 4; v++) begin
               wr(p ? 8'h19 : 8'h04, 8'(m << 4));
               modem_rts[p] = v[0];
               tx_buf_empty[p] = v[1];
               repeat (2) @(negedge clk_sys);
               `CHK(rts_pin_n[p], m == 0 ? !v[0] : m == 1 ? v[0] : m == 2 ? v[1] : 1'b1)
            end
      wr(8'h04, 8'h40);
      `CHK(ir_mode, 2'b01)
      $display("t_rts done");
   endtask : t_rts
   task automatic wake_try(input int p, b, input logic [7:0] en, c0, c1, input int ex);
      int seen;
      seen = 0;
      wr(p ? 8'h19 : 8'h04, c0);
      wr(p ? 8'h1a : 8'h05, c1);
      wr(p ? 8'h1b : 8'h06, en);
      `CHK(wake_allowed[p], !c0[6] && !c1[4])
      if (p)
         lines2 = lines2 ^ (5'h10 >> b);
      else
         lines1 = lines1 ^ (5'h10 >> b);
      repeat (4) begin
         @(negedge clk_sys);
         if (remote_wake_req === 1'b1)
            seen++;
      end
      `CHK(seen, ex)
   endtask : wake_try
   task automatic t_wake;
      usb_suspended = 1'b1;
      for (int p = 0; p < 2; p++)
         for (int b = 0; b < 5; b++)
            wake_try(p, b, 8'(1 << b), 8'h00, 8'h00, 1);
      wake_try(0, 0, 8'h02, 8'h00, 8'h00, 0);
      wake_try(0, 0, 8'h01, 8'h00, 8'h10, 0);
      wake_try(0, 0, 8'h01, 8'h40, 8'h00, 0);
      wake_try(1, 4, 8'h10, 8'h00, 8'h10, 0);
      wake_try(1, 4, 8'h10, 8'h40, 8'h00, 0);
      usb_suspended = 1'b0;
      wake_try(0, 0, 8'h01, 8'h00, 8'h00, 0);
      $display("t_wake done");
   endtask : t_wake
   initial begin
      #800000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      t_absent();
      t_badsig();
      t_load();
      t_host();
      t_rts();
      t_wake();
      tally_and_finish();
   end
endmodule : test_spcfg_bank
bind spcfg_bank spcfg_bank_assertions spcfg_bank_assertions_inst (.clk_sys, .nrst, .ee_req,
   .host_valid, .host_app, .host_ack, .host_nak, .load_done, .modem_rts, .tx_buf_empty,
   .lines1, .usb_suspended, .rts_pin_n, .ir_mode, .wake_allowed, .remote_wake_req,
   .port1_cfg, .port2_cfg);
